//--- pkg/acl_key_l4_pkg.sv
// package for the layer-4, tcp flag, oam and payload key field builder
// assumes one byte-wide receive stream and classification results per frame
package acl_key_l4_pkg;

    // ----------------------------------------------------------------
    // frame layout constants
    // ----------------------------------------------------------------
    localparam logic [10:0] ETHERTYPE_FIELD_POS = 11'h00c;   // ethertype after both macs
    localparam logic [10:0] VLAN_TAG_LEN = 11'h004;
    localparam logic [1:0] MAX_VLAN_TAGS = 2'h3;
    localparam logic [15:0] ETHERTYPE_FIELD_CTAG = 16'h8100;
    localparam logic [15:0] ETHERTYPE_FIELD_STAG = 16'h88a8;
    localparam logic [15:0] ETHERTYPE_FIELD_IPV4 = 16'h0800;
    localparam logic [15:0] ETHERTYPE_FIELD_IPV6 = 16'h86dd;
    localparam logic [15:0] ETHERTYPE_FIELD_OAM = 16'h8902;
    localparam logic [10:0] IPV4_HDR_LEN = 11'h014;   // options never parsed
    localparam logic [10:0] IPV6_HDR_LEN = 11'h028;
    localparam logic [10:0] IPV4_PROTO_OFS = 11'h009;
    localparam logic [10:0] IPV6_NXT_OFS = 11'h006;
    localparam logic [7:0] PROTO_TCP = 8'h06;
    localparam logic [7:0] PROTO_UDP = 8'h11;
    localparam logic [10:0] UDP_HDR_LEN = 11'h008;
    localparam logic [10:0] L4_SEQ_OFS = 11'h004;
    localparam logic [10:0] TCP_DOFS_OFS = 11'h00c;
    localparam logic [10:0] TCP_FLAGS_OFS = 11'h00d;
    localparam logic [10:0] OAM_OPCODE_OFS = 11'h001;
    localparam logic [7:0] OAM_OPCODE_CCM = 8'h01;
    localparam logic [10:0] CCM_CNT_OFS = 11'h03a;
    localparam logic [10:0] CCM_CNT_LEN = 11'h00c;   // txfcf, rxfcb, txfcb
    localparam logic [10:0] NO_POS = 11'h7ff;        // position not yet known

    // ----------------------------------------------------------------
    // field sizes
    // ----------------------------------------------------------------
    localparam int RNG_NUM = 8;
    localparam logic [10:0] IP_PAY_BYTES = 11'h00c;      // 96 bits
    localparam logic [10:0] L4_PAY_BYTES = 11'h008;      // 64 bits
    localparam int CUST_LONG_BYTES = 57;                 // 456 bits
    localparam int CUST_SHORT_BYTES = 24;                // 192 bits

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        KEY_MAC_ETHERTYPE_KEY = 3'h0,
        KEY_TCP_OR_UDP_FLAG = 3'h1,
        KEY_GENERIC_IPV4 = 3'h2,
        KEY_SEVEN_TUPLE = 3'h3,
        KEY_CUSTOM_LONG = 3'h4,
        KEY_CUSTOM_SHORT = 3'h5
    } key_sel_type;

    typedef enum logic [2:0] {
        RNG_NONE = 3'h0,
        RNG_SPORT = 3'h1,
        RNG_DPORT = 3'h2,
        RNG_EITHER = 3'h3,
        RNG_VID = 3'h4,
        RNG_DSCP = 3'h5,
        RNG_CUSTOM = 3'h6
    } rng_sel_type;

    typedef struct packed {
        logic valid;
        logic sof;
        logic eof;
        logic [7:0] data;
    } rx_byte_type;

    typedef struct packed {
        key_sel_type keySel;
        logic frameIsEth;          // custom payload starts after ethernet layer
        logic [10:0] longOfs;      // frame pointer for the long custom field
        logic [10:0] shortOfs;     // frame pointer for the short custom field
        logic [11:0] vid;
        logic [5:0] dscp;
    } cls_type;

    typedef struct packed {
        rng_sel_type sel;
        logic [15:0] low;
        logic [15:0] high;
    } rng_cfg_type;

    typedef struct packed {
        key_sel_type keySel;
        logic [7:0] portRangeMask;
        logic portsEqualFlag;
        logic tcpSeqZeroFlag;
        logic tcpFinFlag;
        logic tcpSynFlag;
        logic tcpRstFlag;
        logic tcpPshFlag;
        logic tcpAckFlag;
        logic tcpUrgFlag;
        logic [95:0] ipPayloadField;
        logic [63:0] transportPayloadField;
        logic ccmCountersZeroFlag;
        logic oamFrameFlag;
        logic [15:0] ethertypeField;
        logic [455:0] customPayloadLong;
        logic [191:0] customPayloadShort;
    } key_type;

endpackage

//--- rtl/acl_key_l4.sv
// layer-4, tcp flag, oam and payload key field builder
// assumes bytes arrive in order with sof on the first, eof on the last,
// and that classification results stay stable for the whole frame
//
// Functional notes
// [RULE_01] eight range checkers build the range mask
// [RULE_02] flag when source port equals destination port
// [RULE_03] flag when tcp sequence number is zero
// [RULE_04] copy six tcp control flags separately
// [RULE_05] generic ipv4: 96 bits at header plus 20
// [RULE_06] tcp_or_udp_flag: 64 bits after transport header
// [RULE_07] seven-tuple non-tcp_or_udp_flag: 8 bytes after ip
// [RULE_08] ccm flag when all three counters zero
// [RULE_09] oam flag on 0x8902, ethertype carries levels
// [RULE_10] long custom: 57 bytes from frame pointer
// [RULE_11] short custom: 24 bytes from frame pointer
// [RULE_12] ethernet frames: custom starts after ethernet layer
// [RULE_13] fields appear only in their own key types
`timescale 1ns/1ns
module acl_key_l4 (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire acl_key_l4_pkg::rx_byte_type rxIn,
    input wire acl_key_l4_pkg::cls_type clsIn,
    input wire acl_key_l4_pkg::rng_cfg_type [7:0] rngCfg,
    output acl_key_l4_pkg::key_type keyOut,
    output logic keyValid
);
    import acl_key_l4_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // byte position falls inside a window of n bytes starting at base
    function automatic logic inWin(input logic [10:0] p, input logic [10:0] base,
                                   input logic [10:0] n);
        inWin = (p >= base) && ({1'b0, p} < ({1'b0, base} + {1'b0, n}));
    endfunction

    function automatic logic inRange(input logic [15:0] v, input logic [15:0] lo,
                                     input logic [15:0] hi);
        inRange = (v >= lo) && (v <= hi);
    endfunction

    // ----------------------------------------------------------------
    // parse state
    // ----------------------------------------------------------------
    logic [10:0] posReg;
    logic [10:0] etPosReg;
    logic [1:0] tagsReg;
    logic [7:0] etHiReg;
    logic [15:0] etherReg;
    logic [10:0] l3BaseReg;
    logic [7:0] protoReg;
    logic [15:0] sportReg;
    logic [15:0] dportReg;
    logic [31:0] seqReg;
    logic [3:0] dofsReg;
    logic [7:0] tcpFlagsReg;
    logic [95:0] ipPayReg;
    logic [63:0] l4PayReg;
    logic [7:0] oamMelReg;
    logic [7:0] oamOpReg;
    logic ccmNonZeroReg;
    logic ccmSeenReg;
    logic doneReg;
    logic [7:0] custLong [CUST_LONG_BYTES];
    logic [7:0] custShort [CUST_SHORT_BYTES];

    logic [10:0] pos;
    logic isV4;
    logic isV6;
    logic isTcp;
    logic isTcpUdp;
    logic [10:0] protoPos;
    logic [10:0] l4Base;
    logic [10:0] payStart;
    logic [10:0] longStart;
    logic [10:0] shortStart;
    logic [15:0] etWord;
    logic [10:0] longIdx;
    logic [10:0] shortIdx;

    // position and derived windows; pointers are only meaningful once known
    always_comb begin
        pos = rxIn.sof ? 11'h000 : posReg;
        etWord = {etHiReg, rxIn.data};
        isV4 = (etherReg == ETHERTYPE_FIELD_IPV4);
        isV6 = (etherReg == ETHERTYPE_FIELD_IPV6);
        isTcp = (isV4 || isV6) && (protoReg == PROTO_TCP);
        isTcpUdp = isTcp || ((isV4 || isV6) && (protoReg == PROTO_UDP));
        protoPos = isV4 ? l3BaseReg + IPV4_PROTO_OFS : l3BaseReg + IPV6_NXT_OFS;
        l4Base = NO_POS;
        if (isV4) begin
            l4Base = l3BaseReg + IPV4_HDR_LEN; // [RULE_05] [RULE_07]
        end else if (isV6) begin
            l4Base = l3BaseReg + IPV6_HDR_LEN;
        end
        // non tcp_or_udp_flag payload starts right after the ip header
        payStart = l4Base; // [RULE_07]
        if (isTcp) begin
            payStart = l4Base + {5'h00, dofsReg, 2'h0}; // [RULE_06]
        end else if (isTcpUdp) begin
            payStart = l4Base + UDP_HDR_LEN; // [RULE_06]
        end
        longStart = clsIn.frameIsEth ? l3BaseReg : clsIn.longOfs; // [RULE_10] [RULE_12]
        shortStart = clsIn.frameIsEth ? l3BaseReg : clsIn.shortOfs; // [RULE_11] [RULE_12]
        longIdx = pos - longStart;
        shortIdx = pos - shortStart;
    end

    // ----------------------------------------------------------------
    // byte position and ethernet layer
    // ----------------------------------------------------------------
    // counter saturates so a giant frame cannot wrap into early windows
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            posReg <= 11'h000;
        end else if (rxIn.valid) begin
            posReg <= (pos == NO_POS) ? pos : pos + 11'h001;
        end
    end

    // up to three vlan tags are skipped before the ethertype counts
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            etPosReg <= ETHERTYPE_FIELD_POS;
            tagsReg <= 2'h0;
            etHiReg <= 8'h00;
            etherReg <= 16'h0000;
            l3BaseReg <= NO_POS;
        end else if (rxIn.valid) begin
            if (rxIn.sof) begin
                etPosReg <= ETHERTYPE_FIELD_POS;
                tagsReg <= 2'h0;
                etherReg <= 16'h0000;
                l3BaseReg <= NO_POS;
            end
            if (pos == etPosReg) begin
                etHiReg <= rxIn.data;
            end
            if (pos == etPosReg + 11'h001) begin
                if ((etWord == ETHERTYPE_FIELD_CTAG || etWord == ETHERTYPE_FIELD_STAG)
                        && tagsReg != MAX_VLAN_TAGS) begin
                    etPosReg <= etPosReg + VLAN_TAG_LEN;
                    tagsReg <= tagsReg + 2'h1;
                end else begin
                    etherReg <= etWord;
                    l3BaseReg <= pos + 11'h001; // [RULE_12]
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // layer-3 and layer-4 header capture
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            protoReg <= 8'h00;
            sportReg <= 16'h0000;
            dportReg <= 16'h0000;
            seqReg <= 32'h0000_0000;
            dofsReg <= 4'h0;
            tcpFlagsReg <= 8'h00;
        end else if (rxIn.valid) begin
            if (rxIn.sof) begin
                protoReg <= 8'h00;
                tcpFlagsReg <= 8'h00;
                seqReg <= 32'hffff_ffff;  // overwritten by bytes 3 to 6 before the ethertype is known, so short frames can look like seq zero
            end
            if ((isV4 || isV6) && pos == protoPos) begin
                protoReg <= rxIn.data;
            end
            if (inWin(pos, l4Base, 11'h002)) begin
                sportReg <= {sportReg[7:0], rxIn.data};
            end
            if (inWin(pos, l4Base + 11'h002, 11'h002)) begin
                dportReg <= {dportReg[7:0], rxIn.data};
            end
            if (inWin(pos, l4Base + L4_SEQ_OFS, 11'h004)) begin
                seqReg <= {seqReg[23:0], rxIn.data}; // [RULE_03]
            end
            if (pos == l4Base + TCP_DOFS_OFS) begin
                dofsReg <= rxIn.data[7:4];
            end
            if (pos == l4Base + TCP_FLAGS_OFS) begin
                tcpFlagsReg <= rxIn.data; // [RULE_04]
            end
        end
    end

    // ----------------------------------------------------------------
    // payload capture
    // ----------------------------------------------------------------
    // fields shift in msb first, so the first payload byte lands on top
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ipPayReg <= 96'h0;
            l4PayReg <= 64'h0;
        end else if (rxIn.valid) begin
            if (rxIn.sof) begin
                ipPayReg <= 96'h0;
                l4PayReg <= 64'h0;
            end
            if (isV4 && inWin(pos, l4Base, IP_PAY_BYTES)) begin
                ipPayReg <= {ipPayReg[87:0], rxIn.data}; // [RULE_05]
            end
            if (inWin(pos, payStart, L4_PAY_BYTES)) begin
                l4PayReg <= {l4PayReg[55:0], rxIn.data}; // [RULE_06] [RULE_07]
            end
        end
    end

    // custom windows; arrays are not cleared, unfilled bytes are masked at key time
    always_ff @(posedge sys_clk) begin
        if (rxIn.valid && inWin(pos, longStart, 11'(CUST_LONG_BYTES))) begin
            custLong[longIdx[5:0]] <= rxIn.data; // [RULE_10]
        end
        if (rxIn.valid && inWin(pos, shortStart, 11'(CUST_SHORT_BYTES))) begin
            custShort[shortIdx[4:0]] <= rxIn.data; // [RULE_11]
        end
    end

    logic [CUST_LONG_BYTES-1:0] longFillReg;
    logic [CUST_SHORT_BYTES-1:0] shortFillReg;

    // tracks which custom bytes this frame actually delivered
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            longFillReg <= '0;
            shortFillReg <= '0;
        end else if (rxIn.valid) begin
            if (rxIn.sof) begin
                longFillReg <= '0;
                shortFillReg <= '0;
            end
            if (inWin(pos, longStart, 11'(CUST_LONG_BYTES))) begin
                longFillReg[longIdx[5:0]] <= 1'b1;
            end
            if (inWin(pos, shortStart, 11'(CUST_SHORT_BYTES))) begin
                shortFillReg[shortIdx[4:0]] <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // oam capture
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            oamMelReg <= 8'h00;
            oamOpReg <= 8'h00;
            ccmNonZeroReg <= 1'b0;
            ccmSeenReg <= 1'b0;
        end else if (rxIn.valid) begin
            if (rxIn.sof) begin
                oamMelReg <= 8'h00;
                oamOpReg <= 8'h00;
                ccmNonZeroReg <= 1'b0;
                ccmSeenReg <= 1'b0;
            end
            if (pos == l3BaseReg) begin
                oamMelReg <= 8'h01 << rxIn.data[7:5]; // [RULE_09]
            end
            if (pos == l3BaseReg + OAM_OPCODE_OFS) begin
                oamOpReg <= rxIn.data;
            end
            if (inWin(pos, l3BaseReg + CCM_CNT_OFS, CCM_CNT_LEN) && rxIn.data != 8'h00) begin
                ccmNonZeroReg <= 1'b1; // [RULE_08]
            end
            // a truncated ccm must not claim zero counters
            if (pos == l3BaseReg + CCM_CNT_OFS + CCM_CNT_LEN - 11'h001) begin
                ccmSeenReg <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // range checkers
    // ----------------------------------------------------------------
    logic [RNG_NUM-1:0] rngHit;
    logic [15:0] custRngVal;

    // custom range input is the first two bytes of the short custom window
    assign custRngVal = {custShort[0], custShort[1]};

    generate
        for (genvar i = 0; i < RNG_NUM; i++) begin : gRng
            always_comb begin
                unique case (rngCfg[i].sel)
                    RNG_SPORT: rngHit[i] = isTcpUdp
                        && inRange(sportReg, rngCfg[i].low, rngCfg[i].high); // [RULE_01]
                    RNG_DPORT: rngHit[i] = isTcpUdp
                        && inRange(dportReg, rngCfg[i].low, rngCfg[i].high);
                    RNG_EITHER: rngHit[i] = isTcpUdp
                        && (inRange(sportReg, rngCfg[i].low, rngCfg[i].high)
                        || inRange(dportReg, rngCfg[i].low, rngCfg[i].high));
                    RNG_VID: rngHit[i] = inRange({4'h0, clsIn.vid},
                        rngCfg[i].low, rngCfg[i].high);
                    RNG_DSCP: rngHit[i] = inRange({10'h000, clsIn.dscp},
                        rngCfg[i].low, rngCfg[i].high);
                    RNG_CUSTOM: rngHit[i] = &shortFillReg[1:0]
                        && inRange(custRngVal, rngCfg[i].low, rngCfg[i].high);
                    default: rngHit[i] = 1'b0;
                endcase
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // key assembly, two cycles after the last byte
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            doneReg <= 1'b0;
        end else begin
            doneReg <= rxIn.valid && rxIn.eof;
        end
    end

    logic l4Key;
    logic macKey;
    logic oamHit;
    logic [455:0] longFlat;
    logic [191:0] shortFlat;

    always_comb begin
        l4Key = (clsIn.keySel == KEY_TCP_OR_UDP_FLAG) || (clsIn.keySel == KEY_SEVEN_TUPLE);
        macKey = (clsIn.keySel == KEY_MAC_ETHERTYPE_KEY);
        oamHit = (etherReg == ETHERTYPE_FIELD_OAM);
        for (int b = 0; b < CUST_LONG_BYTES; b++) begin
            longFlat[455 - 8*b -: 8] = longFillReg[b] ? custLong[b] : 8'h00;
        end
        for (int b = 0; b < CUST_SHORT_BYTES; b++) begin
            shortFlat[191 - 8*b -: 8] = shortFillReg[b] ? custShort[b] : 8'h00;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            keyOut <= '0;
            keyValid <= 1'b0;
        end else begin
            keyValid <= doneReg;
            if (doneReg) begin
                keyOut <= '0;
                keyOut.keySel <= clsIn.keySel;
                if (l4Key) begin // [RULE_13]
                    keyOut.portRangeMask <= rngHit; // [RULE_01]
                    keyOut.portsEqualFlag <= isTcpUdp && (sportReg == dportReg); // [RULE_02]
                    keyOut.tcpSeqZeroFlag <= isTcp && (seqReg == 32'h0000_0000); // [RULE_03]
                    keyOut.tcpFinFlag <= isTcp && tcpFlagsReg[0]; // [RULE_04]
                    keyOut.tcpSynFlag <= isTcp && tcpFlagsReg[1];
                    keyOut.tcpRstFlag <= isTcp && tcpFlagsReg[2];
                    keyOut.tcpPshFlag <= isTcp && tcpFlagsReg[3];
                    keyOut.tcpAckFlag <= isTcp && tcpFlagsReg[4];
                    keyOut.tcpUrgFlag <= isTcp && tcpFlagsReg[5];
                    if (isTcpUdp || (clsIn.keySel == KEY_SEVEN_TUPLE)) begin
                        keyOut.transportPayloadField <= l4PayReg; // [RULE_06] [RULE_07]
                    end
                end
                if (clsIn.keySel == KEY_GENERIC_IPV4 && isV4) begin
                    keyOut.ipPayloadField <= ipPayReg; // [RULE_05] [RULE_13]
                end
                if (macKey) begin // [RULE_13]
                    keyOut.oamFrameFlag <= oamHit; // [RULE_09]
                    keyOut.ethertypeField <= oamHit ? {8'h00, oamMelReg} : etherReg; // [RULE_09]
                    keyOut.ccmCountersZeroFlag <= oamHit && oamOpReg == OAM_OPCODE_CCM
                        && ccmSeenReg && !ccmNonZeroReg; // [RULE_08]
                end
                if (clsIn.keySel == KEY_CUSTOM_LONG) begin
                    keyOut.customPayloadLong <= longFlat; // [RULE_10]
                end
                if (clsIn.keySel == KEY_CUSTOM_SHORT) begin
                    keyOut.customPayloadShort <= shortFlat; // [RULE_11]
                end
            end
        end
    end
endmodule

//--- tb/acl_key_l4_bench.sv
// self-checking bench for the layer-4 key field builder
// assumes the design package; frames built in a byte table
`timescale 1ns/1ns
module acl_key_l4_bench;
    import acl_key_l4_pkg::*;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
    $display("wrong value at %0t: %h expected %h", $time, a, b); end end
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic keyValid;
    rx_byte_type rxIn = '0;
    cls_type clsIn = '0;
    rng_cfg_type [7:0] rngCfg = '0;
    key_type keyOut;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [31:0] lfsr = 32'h4dff8b79;
    logic [7:0] fr [0:127];
    logic [7:0] m;
    acl_key_l4 u_dut (.sys_clk(sys_clk), .nrst(nrst), .rxIn(rxIn), .clsIn(clsIn),
        .rngCfg(rngCfg), .keyOut(keyOut), .keyValid(keyValid));
    // ----------------------------------------------------------------
    // clock, timeout, helpers
    // ----------------------------------------------------------------
    always #50 sys_clk = ~sys_clk;
    // ceiling well above the few thousand cycles the tests need
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    // big-endian byte grab, first byte most significant
    function automatic logic [455:0] grab(input int p, input int n);
        logic [455:0] r = '0;
        for (int i = 0; i < n; i++) r = {r[447:0], fr[p + i]};
        return r;
    endfunction
    function automatic logic inr(input logic [15:0] v, input int i);
        return v >= rngCfg[i].low && v <= rngCfg[i].high;
    endfunction
    function automatic void ipv4(input logic [7:0] proto);
        for (int i = 0; i < 128; i++) fr[i] = rnd();
        {fr[12], fr[13], fr[14], fr[23]} = {ETHERTYPE_FIELD_IPV4, 8'h45, proto};
        fr[46] = {4'(5 + rnd() % 4), 4'h0};
    endfunction
    // drive a whole frame, then look at the pulse one edge after the next
    task automatic run(input key_sel_type k, input int len);
        clsIn.keySel = k;
        for (int i = 0; i < len; i++) begin
            @(negedge sys_clk);
            rxIn = {1'b1, i == 0, i == len - 1, fr[i]};
        end
        @(negedge sys_clk);
        rxIn = '0;
        @(posedge sys_clk);
        #1;
        `CHK(keyValid, 1'b1)
        // callers change inputs only on the falling edge
        @(negedge sys_clk);
    endtask
    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        clsIn.frameIsEth = 1'b1;
        repeat (10) @(negedge sys_clk);
        nrst = 1'b1;
        for (int it = 0; it < 24; it++) begin
            ipv4(PROTO_TCP);
            {clsIn.vid, clsIn.dscp} = rnd();
            for (int i = 0; i < 8; i++) begin
                rngCfg[i].sel = rng_sel_type'(i % 7);
                rngCfg[i].low = (i == 6) ? 16'h0000 : 16'(rnd() % 64);
                rngCfg[i].high = (i == 6) ? 16'hffff : rngCfg[i].low + 16'(rnd() % 64);
            end
            if (it % 2 == 0) {fr[34], fr[36]} = 16'h0000;
            if (it % 3 == 0) {fr[36], fr[37]} = {fr[34], fr[35]};
            if (it % 4 == 0) {fr[38], fr[39], fr[40], fr[41]} = 32'h0;
            run(KEY_TCP_OR_UDP_FLAG, 90);
            for (int i = 0; i < 8; i++) begin
                case (rngCfg[i].sel)
                    RNG_SPORT: m[i] = inr({fr[34], fr[35]}, i);
                    RNG_DPORT: m[i] = inr({fr[36], fr[37]}, i);
                    RNG_EITHER: m[i] = inr({fr[34], fr[35]}, i) || inr({fr[36], fr[37]}, i);
                    RNG_VID: m[i] = inr({4'h0, clsIn.vid}, i);
                    RNG_DSCP: m[i] = inr({10'h0, clsIn.dscp}, i);
                    RNG_CUSTOM: m[i] = 1'b1;
                    default: m[i] = 1'b0;
                endcase
            end
            `CHK(keyOut.portRangeMask, m)
            `CHK(keyOut.portsEqualFlag, {fr[34], fr[35]} == {fr[36], fr[37]})
            `CHK(keyOut.tcpSeqZeroFlag, grab(38, 4) == 0)
            `CHK({keyOut.tcpUrgFlag, keyOut.tcpAckFlag, keyOut.tcpPshFlag, keyOut.tcpRstFlag,
                keyOut.tcpSynFlag, keyOut.tcpFinFlag}, fr[47][5:0])
            `CHK(keyOut.transportPayloadField, grab(34 + fr[46][7:4] * 4, 8))
            run(KEY_GENERIC_IPV4, 90);
            `CHK(keyOut.ipPayloadField, grab(34, 12))
            `CHK(keyOut.portRangeMask, 8'h00)
        end
        $display("test tcp and generic done");
        ipv4(8'h01);
        run(KEY_SEVEN_TUPLE, 60);
        `CHK(keyOut.transportPayloadField, grab(34, 8))
        `CHK(keyOut.tcpSynFlag, 1'b0)
        {fr[12], fr[13], fr[20], fr[56], fr[57]} = {ETHERTYPE_FIELD_IPV6, PROTO_UDP, fr[54], fr[55]};
        run(KEY_SEVEN_TUPLE, 80);
        `CHK(keyOut.transportPayloadField, grab(62, 8))
        `CHK(keyOut.portsEqualFlag, 1'b1)
        $display("test seven-tuple done");
        for (int mel = 0; mel < 8; mel++) begin
            for (int i = 0; i < 128; i++) fr[i] = (i >= 72 && i < 84 && mel % 2 == 0) ? 8'h00 : rnd();
            {fr[12], fr[13], fr[14], fr[15]} = {ETHERTYPE_FIELD_OAM, 3'(mel), 5'h00, OAM_OPCODE_CCM};
            run(KEY_MAC_ETHERTYPE_KEY, 100);
            `CHK(keyOut.oamFrameFlag, 1'b1)
            `CHK(keyOut.ethertypeField, 16'h0001 << mel)
            `CHK(keyOut.ccmCountersZeroFlag, mel % 2 == 0)
        end
        $display("test oam done");
        ipv4(PROTO_UDP);
        {fr[12], fr[13], fr[16], fr[17]} = {ETHERTYPE_FIELD_CTAG, ETHERTYPE_FIELD_IPV4};
        run(KEY_CUSTOM_LONG, 100);
        `CHK(keyOut.customPayloadLong, grab(18, 57))
        {clsIn.frameIsEth, clsIn.shortOfs} = {1'b0, 11'h005};
        run(KEY_CUSTOM_SHORT, 100);
        `CHK(keyOut.customPayloadShort, grab(5, 24))
        $display("test custom done");
        report_and_stop();
    end
endmodule

//--- tb/acl_key_l4_props.sv
// assertions on the layer-4 key field builder ports
// assumes only the top module ports; bound at the foot of this file
`timescale 1ns/1ns
module acl_key_l4_props (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire acl_key_l4_pkg::rx_byte_type rxIn,
    input wire acl_key_l4_pkg::cls_type clsIn,
    input wire acl_key_l4_pkg::rng_cfg_type [7:0] rngCfg,
    input wire acl_key_l4_pkg::key_type keyOut,
    input wire logic keyValid
);
    import acl_key_l4_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    logic [7:0] offMask;
    logic l4Key;
    // checkers switched off may never report a hit
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            offMask[i] = rngCfg[i].sel == RNG_NONE;
        end
    end
    assign l4Key = keyOut.keySel == KEY_TCP_OR_UDP_FLAG || keyOut.keySel == KEY_SEVEN_TUPLE;
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    answer_latency_a: assert property (rxIn.valid && rxIn.eof |=> ##1 keyValid)
        else $error("no key two cycles after the last byte");
    pulse_cause_a: assert property (keyValid |-> $past(rxIn.valid && rxIn.eof, 2))
        else $error("key pulse without a last byte");
    key_hold_a: assert property (!keyValid |-> $stable(keyOut))
        else $error("key changed without a pulse");
    key_type_a: assert property (keyValid |-> keyOut.keySel == $past(clsIn.keySel))
        else $error("key type differs from classification");
    l4_only_a: assert property (keyValid && !l4Key |-> keyOut.portRangeMask == 8'h00 &&
        {keyOut.tcpFinFlag, keyOut.tcpSynFlag, keyOut.tcpAckFlag, keyOut.portsEqualFlag} == 4'h0
        && keyOut.transportPayloadField == 64'h0) else $error("layer-4 field outside its keys");
    ip_only_a: assert property (keyValid && keyOut.keySel != KEY_GENERIC_IPV4 |->
        keyOut.ipPayloadField == 96'h0) else $error("ip payload outside its key");
    oam_only_a: assert property (keyValid && keyOut.keySel != KEY_MAC_ETHERTYPE_KEY |->
        !keyOut.oamFrameFlag && !keyOut.ccmCountersZeroFlag) else $error("oam flag outside key");
    oam_level_a: assert property (keyValid && keyOut.oamFrameFlag |->
        keyOut.ethertypeField[15:8] == 8'h00 && $onehot(keyOut.ethertypeField[7:0]))
        else $error("oam ethertype field not a level flag");
    ccm_needs_oam_a: assert property (keyValid && keyOut.ccmCountersZeroFlag |->
        keyOut.oamFrameFlag) else $error("ccm flag on a non-oam frame");
    range_off_a: assert property (keyValid |-> (keyOut.portRangeMask & $past(offMask)) == 8'h00)
        else $error("idle range checker hit");
endmodule
bind acl_key_l4 acl_key_l4_props u_props (.sys_clk(sys_clk), .nrst(nrst), .rxIn(rxIn),
    .clsIn(clsIn), .rngCfg(rngCfg), .keyOut(keyOut), .keyValid(keyValid));
